/* src/fsr_pkg.sv */
// package for the fault supervision reporter
// assumes one 20 MHz clock, no software bus, fault sources given as flags
package fsr_pkg;

   // ************************************************
   // fault codes
   // ************************************************
   localparam logic [7:0] FSR_CODE_NONE = 8'h00;
   localparam logic [7:0] FSR_CODE_STD_RELAY_FIRST = 8'h04;
   localparam logic [7:0] FSR_CODE_STD_ENABLE = 8'h09;
   localparam logic [7:0] FSR_CODE_STD_CHECK_FIRST = 8'h0A;
   localparam logic [7:0] FSR_CODE_OPT_RELAY_FIRST = 8'h0D;
   localparam logic [7:0] FSR_CODE_OPT_ENABLE = 8'h10;
   localparam logic [7:0] FSR_CODE_OPT_CHECK_FIRST = 8'h11;
   localparam logic [7:0] FSR_CODE_SUPPLY_DIP_FIRST = 8'h14;
   localparam logic [7:0] FSR_CODE_PROGRAM_MEM = 8'h1E;
   localparam logic [7:0] FSR_CODE_WORK_MEM_A = 8'h32;
   localparam logic [7:0] FSR_CODE_WORK_MEM_B = 8'h3B;
   localparam logic [7:0] FSR_CODE_PARAM_MEM_FIRST = 8'h33;
   localparam logic [7:0] FSR_CODE_PARAM_MEM_LAST = 8'h38;
   localparam logic [7:0] FSR_CODE_CALIBRATION = 8'h37;
   localparam logic [7:0] FSR_CODE_IO_MODULE_FIRST = 8'h50;
   localparam logic [7:0] FSR_CODE_SUPPLY_MOD_FIRST = 8'h55;
   localparam logic [7:0] FSR_CODE_HW_CONFIG = 8'h5A;
   localparam logic [7:0] FSR_CODE_COMM_UNKNOWN = 8'h5F;
   localparam logic [7:0] FSR_CODE_PROTO_CONFIG = 8'h68;
   localparam logic [7:0] FSR_CODE_LIGHT_SENSOR_2 = 8'hF0;
   localparam logic [7:0] FSR_CODE_LIGHT_SENSOR_1 = 8'hF1;
   localparam logic [7:0] FSR_CODE_MEASURING = 8'hFD;
   localparam int FSR_REF_CODES = 6;
   localparam logic [7:0] FSR_REF_CODE_TABLE [FSR_REF_CODES] =
      '{8'h83, 8'h8B, 8'hC3, 8'hCB, 8'hDE, 8'hDF};

   // ************************************************
   // warning weights, one bit each
   // ************************************************
   localparam int FSR_WARN_BITS = 7;
   localparam int FSR_WARN_BATTERY = 0;
   localparam int FSR_WARN_TRIP_CIRCUIT = 1;
   localparam int FSR_WARN_SUPPLY_TEMP = 2;
   localparam int FSR_WARN_COMM_MODULE = 3;
   localparam int FSR_WARN_PROTO_CONFIG = 4;
   localparam int FSR_WARN_PROTO_MODULE = 5;
   localparam int FSR_WARN_LIGHT = 6;
   localparam logic [6:0] FSR_WARN_SUM_MAX = 7'h7F;

   // ************************************************
   // timing and reset values
   // ************************************************
   localparam int FSR_CLK_HZ = 20000000;
   localparam int FSR_BLINK_HALF_MS = 250;
   localparam int FSR_BLINK_HALF_CYC = FSR_CLK_HZ / 1000 * FSR_BLINK_HALF_MS;
   localparam int FSR_RESTART_TRIES = 3;
   localparam logic [7:0] FSR_CODE_RESET = 8'h00;

   typedef enum logic [1:0] {FSR_ST_NORMAL, FSR_ST_RESTART, FSR_ST_FAULT} fsr_state_e;

   // output contacts: 3 heavy trip, 5 signal
   typedef struct packed {
      logic [2:0] heavy_trip_output;
      logic [4:0] signal_output;
   } fsr_contacts_s;

   // front panel view
   typedef struct packed {
      logic ready_led;
      logic show_fault;
      logic [7:0] fault_code;
      logic show_warning;
      logic [6:0] warning_code;
   } fsr_panel_s;

endpackage

/* src/fsr_reporter.sv */
// fault supervision reporter: restart, latch, blink, lock, code display
// assumes fault sources are synchronous one-hot-ish request flags
`timescale 1ns/1ps
`default_nettype none

module fsr_reporter #(
   parameter int BLINK_HALF_CYC = fsr_pkg::FSR_BLINK_HALF_CYC,
   parameter int RESTART_TRIES = fsr_pkg::FSR_RESTART_TRIES,
   parameter int SETTINGS_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic fault_active,
   input wire logic [7:0] fault_code_in,
   input wire logic restart_done,
   output logic restart_req,
   input wire logic [fsr_pkg::FSR_WARN_BITS-1:0] warning_active,
   input wire logic warning_routing_switch,
   input wire logic clear_req,
   input wire fsr_pkg::fsr_contacts_s contacts_in,
   input wire logic [7:0] other_code_in,
   input wire logic other_show_in,
   input wire logic [SETTINGS_W-1:0] proto_settings_in,
   output logic [SETTINGS_W-1:0] proto_settings_out,
   output fsr_pkg::fsr_contacts_s contacts_out,
   output logic internal_fault_contact,
   output fsr_pkg::fsr_panel_s panel,
   output logic [7:0] fault_code_status,
   output logic code_valid
);

   // ************************************************
   // state
   // ************************************************
   localparam int BW = $clog2(BLINK_HALF_CYC + 1);

   typedef struct packed {
      fsr_pkg::fsr_state_e state;
      logic [3:0] tries;
      logic [BW-1:0] blink_cnt;
      logic blink;
      logic [7:0] code;
      logic latched;
      logic valid; // code was in the known set when latched
      fsr_pkg::fsr_contacts_s contacts;
      fsr_pkg::fsr_panel_s panel;
      logic [SETTINGS_W-1:0] settings;
   } fsr_state_s;

   fsr_state_s st_reg;
   fsr_state_s st_next;

   // code classes, a weighted sum and known-code check
   logic code_known;
   logic [6:0] warn_sum;
   logic permanent;

   // weights are powers of two, so the sum is simply the flag vector
   always_comb
   begin
      warn_sum = warning_active;
   end

   // recognised codes; unknown codes still latch, flagged as not known
   always_comb
   begin
      code_known = 1'b0;
      if (fault_code_in >= fsr_pkg::FSR_CODE_STD_RELAY_FIRST && fault_code_in <= 8'h08)
         code_known = 1'b1;
      else if (fault_code_in == fsr_pkg::FSR_CODE_STD_ENABLE || (fault_code_in >= fsr_pkg::FSR_CODE_STD_CHECK_FIRST
               && fault_code_in <= 8'h0C))
         code_known = 1'b1;
      else if (fault_code_in >= fsr_pkg::FSR_CODE_OPT_RELAY_FIRST && fault_code_in <= 8'h13)
         code_known = 1'b1;
      else if (fault_code_in == fsr_pkg::FSR_CODE_SUPPLY_DIP_FIRST || fault_code_in == 8'h15
               || fault_code_in == fsr_pkg::FSR_CODE_PROGRAM_MEM || fault_code_in == fsr_pkg::FSR_CODE_WORK_MEM_A
               || fault_code_in == fsr_pkg::FSR_CODE_WORK_MEM_B)
         code_known = 1'b1;
      else if (fault_code_in >= fsr_pkg::FSR_CODE_PARAM_MEM_FIRST && fault_code_in <= fsr_pkg::FSR_CODE_PARAM_MEM_LAST)
         code_known = 1'b1;
      else if ((fault_code_in >= fsr_pkg::FSR_CODE_IO_MODULE_FIRST && fault_code_in <= 8'h52)
               || fault_code_in == fsr_pkg::FSR_CODE_SUPPLY_MOD_FIRST || fault_code_in == 8'h56
               || fault_code_in == fsr_pkg::FSR_CODE_HW_CONFIG || fault_code_in == fsr_pkg::FSR_CODE_COMM_UNKNOWN)
         code_known = 1'b1;
      else if (fault_code_in == fsr_pkg::FSR_CODE_PROTO_CONFIG || fault_code_in == fsr_pkg::FSR_CODE_LIGHT_SENSOR_2
               || fault_code_in == fsr_pkg::FSR_CODE_LIGHT_SENSOR_1 || fault_code_in == fsr_pkg::FSR_CODE_MEASURING)
         code_known = 1'b1;
      else
      begin
         for (int i = 0; i < fsr_pkg::FSR_REF_CODES; i++)
         begin
            if (fault_code_in == fsr_pkg::FSR_REF_CODE_TABLE[i])
               code_known = 1'b1;
         end
      end
   end

   // ************************************************
   // next state
   // ************************************************
   always_comb
   begin
      st_next = st_reg;
      permanent = (st_reg.state == fsr_pkg::FSR_ST_FAULT);
      case (st_reg.state)
         fsr_pkg::FSR_ST_NORMAL:
         begin
            st_next.tries = 4'h0;
            if (fault_active)
               st_next.state = fsr_pkg::FSR_ST_RESTART;
         end
         fsr_pkg::FSR_ST_RESTART:
         begin
            // one restart per try; fault surviving all tries is permanent
            if (!fault_active)
               st_next.state = fsr_pkg::FSR_ST_NORMAL;
            else if (restart_done)
            begin
               if (st_reg.tries >= 4'(RESTART_TRIES - 1))
               begin
                  st_next.state = fsr_pkg::FSR_ST_FAULT;
                  st_next.code = fault_code_in;
                  st_next.latched = 1'b1;
                  st_next.valid = code_known;
                  st_next.blink_cnt = '0;
                  st_next.blink = 1'b0;
               end
               else
                  st_next.tries = st_reg.tries + 4'h1;
            end
         end
         fsr_pkg::FSR_ST_FAULT:
         begin
            // blink phase counter
            if (st_reg.blink_cnt >= BW'(BLINK_HALF_CYC - 1))
            begin
               st_next.blink_cnt = '0;
               st_next.blink = ~st_reg.blink;
            end
            else
               st_next.blink_cnt = st_reg.blink_cnt + BW'(1);
            if (!fault_active)
               st_next.state = fsr_pkg::FSR_ST_NORMAL;
         end
         default:
            st_next.state = fsr_pkg::FSR_ST_NORMAL;
      endcase

      // clear honoured only when not blinking; fault latch wins over clear
      if (clear_req && !permanent && st_next.state != fsr_pkg::FSR_ST_FAULT)
      begin
         st_next.latched = 1'b0;
         st_next.valid = 1'b0;
         st_next.code = fsr_pkg::FSR_CODE_NONE;
      end

      // contacts: locked to initial state while fault persists
      if (st_next.state == fsr_pkg::FSR_ST_FAULT)
         st_next.contacts = '0;
      else
      begin
         st_next.contacts = contacts_in;
         if (warning_routing_switch && warning_active[fsr_pkg::FSR_WARN_TRIP_CIRCUIT])
            st_next.contacts.signal_output[1] = 1'b1;
      end

      // panel: internal fault first, then other indications, then warnings
      st_next.panel.ready_led = (st_next.state == fsr_pkg::FSR_ST_FAULT) ? st_next.blink : 1'b1;
      st_next.panel.show_fault = st_next.latched;
      st_next.panel.show_warning = 1'b0;
      st_next.panel.warning_code = 7'h00;
      if (st_next.latched)
         st_next.panel.fault_code = st_next.code;
      else if (other_show_in)
         st_next.panel.fault_code = other_code_in;
      else
      begin
         st_next.panel.fault_code = fsr_pkg::FSR_CODE_NONE;
         st_next.panel.show_warning = (warn_sum != 7'h00);
         st_next.panel.warning_code = warn_sum;
      end

      // related settings read as zero during protocol configuration error
      st_next.settings = warning_active[fsr_pkg::FSR_WARN_PROTO_CONFIG] ? '0 : proto_settings_in;
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.state <= fsr_pkg::FSR_ST_NORMAL;
         st_reg.tries <= 4'h0;
         st_reg.blink_cnt <= '0;
         st_reg.blink <= 1'b0;
         st_reg.code <= fsr_pkg::FSR_CODE_RESET;
         st_reg.latched <= 1'b0;
         st_reg.valid <= 1'b0;
         st_reg.contacts <= '0;
         st_reg.panel <= '0;
         st_reg.settings <= '0;
      end
      else
         st_reg <= st_next;
   end

   // outputs
   assign restart_req = (st_reg.state == fsr_pkg::FSR_ST_RESTART);
   assign internal_fault_contact = (st_reg.state == fsr_pkg::FSR_ST_FAULT);
   assign contacts_out = st_reg.contacts;
   assign panel = st_reg.panel;
   assign fault_code_status = st_reg.code;
   assign code_valid = st_reg.latched && st_reg.valid; // registered, so a later input code cannot change it
   assign proto_settings_out = st_reg.settings;

   // ************************************************
   // checks
   // ************************************************
   property p_restart_first;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(internal_fault_contact) |-> $past(restart_req);
   endproperty
   a_restart_first: assert property (p_restart_first) else $error("fault declared without restart");

   property p_contact_lock;
      @(posedge core_clk) disable iff (!rst_n)
      internal_fault_contact |-> contacts_out == '0;
   endproperty
   a_contact_lock: assert property (p_contact_lock) else $error("contacts not locked");

   property p_code_latch;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(internal_fault_contact) |-> fault_code_status == $past(fault_code_in);
   endproperty
   a_code_latch: assert property (p_code_latch) else $error("fault code not latched");

   property p_priority;
      @(posedge core_clk) disable iff (!rst_n)
      panel.show_fault |-> panel.fault_code == fault_code_status && !panel.show_warning;
   endproperty
   a_priority: assert property (p_priority) else $error("fault display overridden");

   property p_no_clear;
      @(posedge core_clk) disable iff (!rst_n)
      internal_fault_contact && clear_req |=> panel.show_fault;
   endproperty
   a_no_clear: assert property (p_no_clear) else $error("clear accepted while blinking");

   property p_stay_latched;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(internal_fault_contact) && !$past(clear_req) |-> fault_code_status == $past(fault_code_status);
   endproperty
   a_stay_latched: assert property (p_stay_latched) else $error("message dropped with fault");

   property p_steady_ready;
      @(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) && !internal_fault_contact && !$past(internal_fault_contact) |-> panel.ready_led;
   endproperty
   a_steady_ready: assert property (p_steady_ready) else $error("ready not steady");

   property p_warn_sum;
      @(posedge core_clk) disable iff (!rst_n)
      panel.show_warning |-> panel.warning_code == $past(warning_active) && panel.warning_code <= 7'h7F;
   endproperty
   a_warn_sum: assert property (p_warn_sum) else $error("warning sum wrong");

   property p_route;
      @(posedge core_clk) disable iff (!rst_n)
      warning_routing_switch && warning_active[1] && !internal_fault_contact
         ##1 !internal_fault_contact |-> contacts_out.signal_output[1];
   endproperty
   a_route: assert property (p_route) else $error("warning not routed");

   property p_zero_settings;
      @(posedge core_clk) disable iff (!rst_n)
      warning_active[4] |=> proto_settings_out == '0;
   endproperty
   a_zero_settings: assert property (p_zero_settings) else $error("settings not zero");

   // further guards on the quiet paths
   property p_restart_req;
      @(posedge core_clk) disable iff (!rst_n)
      fault_active && !restart_req && !internal_fault_contact |=> restart_req;
   endproperty
   a_restart_req: assert property (p_restart_req) else $error("no restart on new fault");

   property p_fault_shown;
      @(posedge core_clk) disable iff (!rst_n)
      internal_fault_contact |-> panel.show_fault;
   endproperty
   a_fault_shown: assert property (p_fault_shown) else $error("fault message missing");

   property p_code_hold;
      @(posedge core_clk) disable iff (!rst_n)
      panel.show_fault && !clear_req && !restart_req |=> $stable(fault_code_status);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("latched code moved");

   property p_settings_pass;
      @(posedge core_clk) disable iff (!rst_n)
      !warning_active[fsr_pkg::FSR_WARN_PROTO_CONFIG] |=> proto_settings_out == $past(proto_settings_in);
   endproperty
   a_settings_pass: assert property (p_settings_pass) else $error("settings not passed");

   property p_warn_kept;
      @(posedge core_clk) disable iff (!rst_n)
      !panel.show_fault && !restart_req && !other_show_in && warning_active != 7'h00 |=> panel.show_warning;
   endproperty
   a_warn_kept: assert property (p_warn_kept) else $error("warning message lost");

   c_fault: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(internal_fault_contact));
   c_recover: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(internal_fault_contact));
   c_warn: cover property (@(posedge core_clk) disable iff (!rst_n) panel.show_warning);
   c_cleared: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(panel.show_fault));
   c_routed: cover property (@(posedge core_clk) disable iff (!rst_n) warning_routing_switch && contacts_out.signal_output[1]);

endmodule

`default_nettype wire

/* testbench/fsr_panel_model.sv */
// front panel and restart partner for the fault supervision reporter
// assumes one core clock; answers restart requests, counts ready blinks
`timescale 1ns/1ps
`default_nettype none

module fsr_panel_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] gap,
   input wire logic restart_req,
   input wire logic internal_fault_contact,
   input wire fsr_pkg::fsr_panel_s panel,
   output logic restart_done,
   output int blink_edges
);
   // ************************************************
   // restart answer and blink watch
   // ************************************************
   int wait_cnt;
   logic led_last;

   // one-cycle pulse after gap idle cycles; the idle cycle after a pulse
   // lets the reporter drop its request before it is looked at again
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         restart_done <= 1'b0;
         wait_cnt <= 0;
         blink_edges <= 0;
         led_last <= 1'b0;
      end
      else
      begin
         led_last <= panel.ready_led;
         if (internal_fault_contact && led_last !== panel.ready_led)
            blink_edges <= blink_edges + 1;
         if (restart_done)
         begin
            restart_done <= 1'b0;
            wait_cnt <= 0;
         end
         else if (restart_req && wait_cnt >= int'(gap))
            restart_done <= 1'b1;
         else if (restart_req)
            wait_cnt <= wait_cnt + 1;
         else
            wait_cnt <= 0;
      end
   end
endmodule

`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the fault supervision reporter
// assumes the panel model answers restarts; blink half period shortened to 4
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic core_clk, rst_n, fault_active, restart_done, restart_req;
   logic warning_routing_switch, clear_req, other_show_in;
   logic internal_fault_contact, code_valid;
   logic [7:0] fault_code_in, other_code_in, fault_code_status;
   logic [6:0] warning_active;
   logic [15:0] proto_settings_in, proto_settings_out;
   logic [3:0] gap;
   int blink_edges, n_fail, checks_done;
   fsr_pkg::fsr_contacts_s contacts_in, contacts_out;
   fsr_pkg::fsr_panel_s panel;
   localparam logic [7:0] CODES [44] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
      8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1E, 8'h32, 8'h33, 8'h34, 8'h35,
      8'h36, 8'h37, 8'h38, 8'h3B, 8'h50, 8'h51, 8'h52, 8'h55, 8'h56, 8'h5A, 8'h5F, 8'h68, 8'h83, 8'h8B,
      8'hC3, 8'hCB, 8'hDE, 8'hDF, 8'hF0, 8'hF1, 8'hFD};

   fsr_reporter #(.BLINK_HALF_CYC(4), .RESTART_TRIES(3), .SETTINGS_W(16)) dut (.core_clk(core_clk),
      .rst_n(rst_n), .fault_active(fault_active), .fault_code_in(fault_code_in), .restart_done(restart_done),
      .restart_req(restart_req), .warning_active(warning_active), .warning_routing_switch(warning_routing_switch),
      .clear_req(clear_req), .contacts_in(contacts_in), .other_code_in(other_code_in),
      .other_show_in(other_show_in), .proto_settings_in(proto_settings_in),
      .proto_settings_out(proto_settings_out), .contacts_out(contacts_out),
      .internal_fault_contact(internal_fault_contact), .panel(panel), .fault_code_status(fault_code_status),
      .code_valid(code_valid));

   fsr_panel_model panel_model (.core_clk(core_clk), .rst_n(rst_n), .gap(gap), .restart_req(restart_req),
      .internal_fault_contact(internal_fault_contact), .panel(panel), .restart_done(restart_done),
      .blink_edges(blink_edges));

   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // inputs move 1 ns after the edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic results;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wait_contact(input logic lvl);
      int i;
      for (i = 0; i < 200 && internal_fault_contact !== lvl; i++)
         tick(1);
      if (i == 200)
      begin
         n_fail++;
         results();
      end
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   // each weight alone, then all; clear held high must not remove them
   task automatic t_warn;
      contacts_in = 8'h00;
      proto_settings_in = 16'hA5C3;
      warning_routing_switch = 1'b1;
      clear_req = 1'b1;
      for (int b = 0; b < 7; b++)
      begin
         warning_active = 7'h01 << b;
         tick(2);
         chk(panel.warning_code, 32'h1 << b);
         chk(panel.show_warning, 1'b1);
         chk(panel.ready_led, 1'b1);
         chk(contacts_out.signal_output[1], b == 1);
         chk(proto_settings_out, (b == 4) ? 16'h0000 : 16'hA5C3);
      end
      warning_active = 7'h7F;
      tick(2);
      chk(panel.warning_code, 7'h7F);
      warning_active = 7'h02;
      warning_routing_switch = 1'b0;
      tick(2);
      chk(contacts_out, 8'h00);
      warning_active = 7'h00;
      clear_req = 1'b0;
      tick(2);
      chk(panel.show_warning, 1'b0);
      $display("test warn done");
   endtask

   // fault gone after the first restart: never declared
   task automatic t_recover;
      int i;
      int bad;
      bad = 0;
      gap = 4'h3;
      fault_code_in = 8'h1E;
      fault_active = 1'b1;
      for (i = 0; i < 50 && restart_done !== 1'b1; i++)
         tick(1);
      if (i == 50)
      begin
         n_fail++;
         results();
      end
      fault_active = 1'b0;
      repeat (20)
      begin
         tick(1);
         if (internal_fault_contact !== 1'b0)
            bad++;
      end
      chk(bad, 0);
      chk(panel.show_fault, 1'b0);
      $display("test recover done");
   endtask

   // permanent fault: lock, blink, code, refused clear, latch after recovery
   task automatic t_fault(input logic [7:0] code, input logic known);
      int b0;
      contacts_in = 8'hFF;
      other_show_in = 1'b1;
      other_code_in = 8'h01;
      fault_code_in = code;
      fault_active = 1'b1;
      tick(1);
      chk(restart_req, 1'b1);
      chk(internal_fault_contact, 1'b0);
      chk(panel.fault_code, 8'h01);
      wait_contact(1'b1);
      tick(1);
      chk(contacts_out, 8'h00);
      chk(panel.show_fault, 1'b1);
      chk(panel.fault_code, code);
      chk(fault_code_status, code);
      chk(code_valid, known);
      clear_req = 1'b1;
      b0 = blink_edges;
      tick(12);
      chk(blink_edges - b0 >= 2, 1'b1);
      chk(panel.show_fault, 1'b1);
      clear_req = 1'b0;
      fault_active = 1'b0;
      tick(3);
      chk(internal_fault_contact, 1'b0);
      chk(panel.ready_led, 1'b1);
      chk(panel.show_fault, 1'b1);
      chk(fault_code_status, code);
      chk(contacts_out, 8'hFF);
      clear_req = 1'b1;
      tick(2);
      chk(panel.show_fault, 1'b0);
      clear_req = 1'b0;
      other_show_in = 1'b0;
      $display("test fault %h done", code);
   endtask

   // ************************************************
   // clock, watchdog and main sequence
   // ************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      results();
   end

   initial
   begin
      n_fail = 0;
      checks_done = 0;
      rst_n = 1'b0;
      fault_active = 1'b0;
      fault_code_in = 8'h00;
      warning_active = 7'h00;
      warning_routing_switch = 1'b0;
      clear_req = 1'b0;
      contacts_in = 8'h00;
      other_code_in = 8'h00;
      other_show_in = 1'b0;
      proto_settings_in = 16'h0000;
      gap = 4'h0;
      tick(12);
      chk(panel, 18'h00000);
      rst_n = 1'b1;
      tick(2);
      chk(panel.ready_led, 1'b1);
      t_warn();
      t_recover();
      foreach (CODES[i])
      begin
         gap = i[0] ? 4'h2 : 4'h0;
         t_fault(CODES[i], 1'b1);
      end
      t_fault(8'h39, 1'b0);
      results();
   end
endmodule

`default_nettype wire
